// File: rtl/apc_pkg.sv
// constants, field layouts and carrier types of the converter control block
// What this block does
// RL1: select low needed for any access
// RL2: internal mode: write edge latches byte, converts
// RL3: external mode: second write ends acquisition
// RL4: read falling edge enables data drivers
// RL5: byte select picks upper or lower result
// RL6: low pins carry bits 0-3 or 8-11
// RL7: shutdown low forces complete sleep mode
// RL8: done goes low when result ready
// RL9: external clock pin or internal oscillator times
// RL10: timing bit 0 ends acquisition after six
// RL11: every conversion lasts twelve clock cycles
// RL12: select high ignores strobes, bus released
// RL13: upper byte pins 4-7 zero or sign
// RL14: done returns high when reading starts
// RL15: host ends acquisition writing timing bit clear
package apc_pkg;

	// ==========================================================================
	// timing
	localparam int unsigned CLK_FREQ_KHZ     = 100000;
	localparam int unsigned INT_OSC_FREQ_KHZ = 1560;
	// longest period of the internal oscillator, rounded down to whole cycles
	localparam int unsigned INT_OSC_DIV      = CLK_FREQ_KHZ / INT_OSC_FREQ_KHZ;
	localparam logic [3:0]  ACQ_CYCLES       = 4'h6;
	localparam logic [3:0]  CONV_CYCLES      = 4'hc;
	localparam logic [3:0]  MSB_INDEX        = 4'hb;

	// ==========================================================================
	// control byte
	localparam logic [1:0] PCM_EXT_CLOCK    = 2'h0;
	localparam logic [1:0] PCM_INT_CLOCK    = 2'h1;
	localparam logic [1:0] PCM_STANDBY      = 2'h2;
	localparam logic [1:0] PCM_COMPLETE     = 2'h3;
	localparam int unsigned PCM_SLEEP_BIT   = 1;
	localparam int unsigned PCM_CLOCK_BIT   = 0;

	typedef struct packed {
		logic [1:0] power_clock_mode;
		logic       sample_timing_select;
		logic       span_select;
		logic       signed_select;
		logic [2:0] input_channel_select;
	} apc_ctrl_t;

	localparam apc_ctrl_t CTRL_RESET = 8'h00;

	// ==========================================================================
	// pins sampled from outside the clock domain
	typedef struct packed {
		logic       cs_n;
		logic       wr_n;
		logic       rd_n;
		logic       upper_byte_select;
		logic       power_off_n;
		logic       ext_clk;
		logic [7:0] data;
	} apc_pins_t;

	localparam apc_pins_t PINS_IDLE = 14'h3b00;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ACQ_INT = 4'h2,
		ST_ACQ_EXT = 4'h4,
		ST_CONV    = 4'h8
	} apc_state_t;

	localparam logic [11:0] RESULT_RESET = 12'h000;

endpackage

// File: rtl/apc_top.sv
// control and host-bus logic of the eight-channel successive-approximation converter
`timescale 1ns/1ps

module apc_top
	import apc_pkg::*;
#(
	parameter int unsigned OSC_DIV = INT_OSC_DIV
)
(
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        CS_N_IN,
	input  wire logic        WR_N_IN,
	input  wire logic        RD_N_IN,
	input  wire logic        UPPER_BYTE_SELECT_IN,
	input  wire logic        POWER_OFF_N_IN,
	input  wire logic        EXT_CLK_IN,
	input  wire logic [7:0]  DATA_IN,
	input  wire logic        COMPARATOR_IN,
	output logic      [7:0]  DATA_OUT,
	output logic             DATA_OE_N_OUT,
	output logic             DONE_N_OUT,
	output logic             TRACK_OUT,
	output logic      [11:0] TRIAL_CODE_OUT,
	output logic      [2:0]  INPUT_CHANNEL_SELECT_OUT,
	output logic             SPAN_SELECT_OUT,
	output logic             SIGNED_SELECT_OUT,
	output logic             INT_CLOCK_OUT,
	output logic             STANDBY_SLEEP_MODE_OUT,
	output logic             COMPLETE_SLEEP_MODE_OUT
);

	// ==========================================================================
	// pin synchronisers: a change counts once the second and third stages agree
	apc_pins_t sync1;
	apc_pins_t sync2;
	apc_pins_t sync3;
	apc_pins_t pins;
	apc_pins_t pins_prev;
	apc_pins_t next_pins;

	always_comb
	begin
		next_pins = (sync2 & sync3) | (pins & (sync2 ^ sync3));
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			sync1     <= PINS_IDLE;
			sync2     <= PINS_IDLE;
			sync3     <= PINS_IDLE;
			pins      <= PINS_IDLE;
			pins_prev <= PINS_IDLE;
		end
		else
		begin
			sync1     <= {CS_N_IN, WR_N_IN, RD_N_IN, UPPER_BYTE_SELECT_IN, POWER_OFF_N_IN,
				EXT_CLK_IN, DATA_IN};
			sync2     <= sync1;
			sync3     <= sync2;
			pins      <= next_pins;
			pins_prev <= pins;
		end
	end

	// strobes only count while select is low
	logic wr_rise;
	logic rd_fall;
	logic shutdown;
	assign wr_rise  = !pins.cs_n && pins.wr_n && !pins_prev.wr_n;  // RL1 RL12
	assign rd_fall  = !pins.cs_n && !pins.rd_n && pins_prev.rd_n;  // RL1 RL4
	assign shutdown = !pins.power_off_n;

	// ==========================================================================
	// conversion clock: external pin edge or internal oscillator divider
	localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);
	apc_ctrl_t         ctrl;
	logic              int_clock;
	logic [DIV_W-1:0]  div_cnt;
	logic [DIV_W-1:0]  next_div_cnt;
	logic              tick;

	always_comb
	begin
		next_div_cnt = div_cnt + 1'b1;
		if (!int_clock || div_cnt == DIV_W'(OSC_DIV - 1))
			next_div_cnt = '0;
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			div_cnt <= '0;
		else
			div_cnt <= next_div_cnt;
	end

	// the divider only turns over in internal mode, so one tick per wrap
	assign tick = int_clock ? (div_cnt == DIV_W'(OSC_DIV - 1))
		: (pins.ext_clk && !pins_prev.ext_clk);  // RL9

	// ==========================================================================
	// acquisition and conversion sequencer
	apc_state_t  state;
	apc_state_t  next_state;
	apc_ctrl_t   next_ctrl;
	logic        next_int_clock;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [11:0] sar;
	logic [11:0] next_sar;
	logic [11:0] result;
	logic [11:0] next_result;
	logic        done_n;
	logic        next_done_n;
	logic        complete_sleep;
	logic        next_complete_sleep;

	always_comb
	begin
		next_state          = state;
		next_ctrl           = ctrl;
		next_int_clock      = int_clock;
		next_cnt            = cnt;
		next_sar            = sar;
		next_result         = result;
		next_done_n         = done_n;
		next_complete_sleep = shutdown || (ctrl.power_clock_mode == PCM_COMPLETE);  // RL7
		if (rd_fall)
			next_done_n = 1'b1;  // RL14
		case (state)
			ST_ACQ_INT:
			begin
				if (tick)
					next_cnt = cnt + 4'h1;
				if (tick && cnt == ACQ_CYCLES - 4'h1)  // RL10
				begin
					next_state = ST_CONV;
					next_cnt   = '0;
					next_sar   = 12'h800;
				end
			end
			ST_CONV:
			begin
				if (tick)
				begin
					// one decision per conversion clock, most significant first
					next_sar[MSB_INDEX - cnt] = COMPARATOR_IN;
					if (cnt != MSB_INDEX)
						next_sar[MSB_INDEX - cnt - 4'h1] = 1'b1;
					next_cnt = cnt + 4'h1;
				end
				if (tick && cnt == CONV_CYCLES - 4'h1)  // RL11
				begin
					next_result = next_sar;
					next_done_n = 1'b0;  // RL8
					next_state  = ST_IDLE;
					next_cnt    = '0;
				end
			end
			ST_ACQ_EXT, ST_IDLE:
			begin
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
		// a write restarts acquisition from any point; a sleep mode idles, and a clear timing bit in external acquisition converts
		if (wr_rise)
		begin
			next_ctrl = apc_ctrl_t'(pins.data);  // RL2
			next_cnt  = '0;
			if (!next_ctrl.power_clock_mode[PCM_SLEEP_BIT])
				next_int_clock = next_ctrl.power_clock_mode[PCM_CLOCK_BIT];  // RL9
			if (next_ctrl.power_clock_mode[PCM_SLEEP_BIT])
				next_state = ST_IDLE;
			else if (state == ST_ACQ_EXT && !next_ctrl.sample_timing_select)
			begin
				next_state = ST_CONV;  // RL3 RL15
				next_sar   = 12'h800;
			end
			else if (next_ctrl.sample_timing_select)
				next_state = ST_ACQ_EXT;  // RL3
			else
				next_state = ST_ACQ_INT;  // RL2 RL10
		end
		if (shutdown)
		begin
			next_state = ST_IDLE;  // RL7
			next_cnt   = '0;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			state          <= ST_IDLE;
			ctrl           <= CTRL_RESET;
			int_clock      <= 1'b0;
			cnt            <= '0;
			sar            <= RESULT_RESET;
			result         <= RESULT_RESET;
			done_n         <= 1'b1;
			complete_sleep <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			ctrl           <= next_ctrl;
			int_clock      <= next_int_clock;
			cnt            <= next_cnt;
			sar            <= next_sar;
			result         <= next_result;
			done_n         <= next_done_n;
			complete_sleep <= next_complete_sleep;
		end
	end

	// ==========================================================================
	// read side: drivers on from the read falling edge until read or select rise
	function automatic logic [7:0] read_byte(input logic [11:0] r, input logic upper,
		input logic signed_mode);
		if (upper)
			read_byte = {(signed_mode ? {4{r[11]}} : 4'h0), r[11:8]};  // RL5 RL6 RL13
		else
			read_byte = r[7:0];  // RL5 RL6
	endfunction

	logic       oe_n;
	logic       next_oe_n;
	logic [7:0] data_q;
	logic [7:0] next_data_q;

	always_comb
	begin
		next_oe_n = oe_n;
		if (rd_fall)
			next_oe_n = 1'b0;  // RL4
		if (pins.cs_n || pins.rd_n)
			next_oe_n = 1'b1;  // RL12
		// byte select may change during a read, so the bus follows it
		next_data_q = read_byte(result, pins.upper_byte_select, ctrl.signed_select);
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			oe_n   <= 1'b1;
			data_q <= 8'h00;
		end
		else
		begin
			oe_n   <= next_oe_n;
			data_q <= next_data_q;
		end
	end

	// ==========================================================================
	// outputs, all from flip-flops
	logic track;
	logic standby_sleep;
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			track         <= 1'b0;
			standby_sleep <= 1'b0;
		end
		else
		begin
			track         <= (next_state == ST_ACQ_INT) || (next_state == ST_ACQ_EXT);
			standby_sleep <= !next_complete_sleep
				&& (next_ctrl.power_clock_mode == PCM_STANDBY);
		end
	end

	assign DATA_OUT                 = data_q;
	assign DATA_OE_N_OUT            = oe_n;
	assign DONE_N_OUT               = done_n;
	assign TRACK_OUT                = track;
	assign TRIAL_CODE_OUT           = sar;
	assign INPUT_CHANNEL_SELECT_OUT = ctrl.input_channel_select;
	assign SPAN_SELECT_OUT          = ctrl.span_select;
	assign SIGNED_SELECT_OUT        = ctrl.signed_select;
	assign INT_CLOCK_OUT            = int_clock;
	assign STANDBY_SLEEP_MODE_OUT   = standby_sleep;
	assign COMPLETE_SLEEP_MODE_OUT  = complete_sleep;

endmodule // apc_top

// File: tb/apc_top_properties.sv
// port assertions of the converter control block
`timescale 1ns/1ps
// ==========================================================================
// checker
module apc_chk
	import apc_pkg::*;
#(
	parameter int unsigned OSC_DIV = INT_OSC_DIV
)
(
	input wire logic        CLK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic        CS_N_IN,
	input wire logic        RD_N_IN,
	input wire logic        UPPER_BYTE_SELECT_IN,
	input wire logic        POWER_OFF_N_IN,
	input wire logic [7:0]  DATA_OUT,
	input wire logic        DATA_OE_N_OUT,
	input wire logic        DONE_N_OUT,
	input wire logic        TRACK_OUT,
	input wire logic [11:0] TRIAL_CODE_OUT,
	input wire logic        SIGNED_SELECT_OUT,
	input wire logic        INT_CLOCK_OUT,
	input wire logic        COMPLETE_SLEEP_MODE_OUT
);
	logic [15:0] hi_len;
	logic [15:0] cv_len;
	// lengths of tracking and converting; the tick phase is free, hence the slack
	// wide enough for the slowest divide, so neither count wraps within one sequence
	always_ff @(posedge CLK_IN)
	begin
		hi_len <= (TRACK_OUT && !SYS_RST_IN) ? hi_len + 16'h0001 : 16'h0000;
		cv_len <= (SYS_RST_IN || $fell(TRACK_OUT)) ? 16'h0000 : cv_len + 16'h0001;
	end
	default clocking dc @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	a_bus_release: assert property (CS_N_IN [*8] |-> DATA_OE_N_OUT)
		else $error("data bus driven while deselected");
	a_read_gated: assert property ($fell(DATA_OE_N_OUT) |->
		!$past(CS_N_IN, 3) && !$past(RD_N_IN, 3)) else $error("drivers on without read");
	a_done_cleared: assert property ($fell(DATA_OE_N_OUT) |-> ##[0:1] DONE_N_OUT)
		else $error("done stays low at read");
	a_power_off: assert property (!POWER_OFF_N_IN [*8] |->
		COMPLETE_SLEEP_MODE_OUT && !TRACK_OUT) else $error("shutdown not forced");
	a_acq_len: assert property ($fell(TRACK_OUT) && INT_CLOCK_OUT && POWER_OFF_N_IN |->
		hi_len >= 5 * OSC_DIV && hi_len <= 6 * OSC_DIV + 3) else $error("acquire length");
	a_conv_len: assert property ($fell(DONE_N_OUT) && INT_CLOCK_OUT |->
		cv_len >= 12 * OSC_DIV - 1 && cv_len <= 12 * OSC_DIV + 3) else $error("convert length");
	a_sar_start: assert property ($fell(TRACK_OUT) && POWER_OFF_N_IN |->
		##[0:1] TRIAL_CODE_OUT == 12'h800) else $error("conversion not started");
	a_upper_byte: assert property (UPPER_BYTE_SELECT_IN [*8] ##0 !DATA_OE_N_OUT
		|-> DATA_OUT == {{4{SIGNED_SELECT_OUT & TRIAL_CODE_OUT[11]}}, TRIAL_CODE_OUT[11:8]})
		else $error("upper byte wrong");
	a_lower_byte: assert property (!UPPER_BYTE_SELECT_IN [*8] ##0 !DATA_OE_N_OUT
		|-> DATA_OUT == TRIAL_CODE_OUT[7:0]) else $error("lower byte wrong");
endmodule // apc_chk

bind apc_top apc_chk #(.OSC_DIV(OSC_DIV)) i_apc_chk (.CLK_IN, .SYS_RST_IN, .CS_N_IN,
	.RD_N_IN, .UPPER_BYTE_SELECT_IN, .POWER_OFF_N_IN, .DATA_OUT, .DATA_OE_N_OUT,
	.DONE_N_OUT, .TRACK_OUT, .TRIAL_CODE_OUT, .SIGNED_SELECT_OUT, .INT_CLOCK_OUT,
	.COMPLETE_SLEEP_MODE_OUT);

// File: tb/apc_host.sv
// host processor model on the shared byte bus
`timescale 1ns/1ps
// ==========================================================================
// host
module apc_host
(
	input  wire logic       clk,
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic            upper_sel,
	input  wire logic [7:0] dout,
	input  wire logic       oe_n,
	output logic      [7:0] bus
);
	logic [7:0] hd;
	// released bus shows the inverse of the last byte, never a stale copy
	assign bus = oe_n ? hd : dout;
	initial {cs_n, wr_n, rd_n, upper_sel, hd} = 12'he00;
	task automatic wr(input logic [7:0] b, input logic sel);
		@(posedge clk); cs_n <= sel; hd <= b;
		repeat (2) @(posedge clk); wr_n <= 1'b0;
		repeat (6) @(posedge clk); wr_n <= 1'b1;
		repeat (6) @(posedge clk); cs_n <= 1'b1; hd <= ~b;
		// select must stay high long enough to get through the pin filter
		repeat (2) @(posedge clk);
	endtask
	task automatic rd(input logic up, input logic sel, output logic [7:0] q);
		int n;
		@(posedge clk); cs_n <= sel; upper_sel <= up;
		repeat (2) @(posedge clk); rd_n <= 1'b0;
		for (n = 0; n < 20 && oe_n !== 1'b0; n++) @(posedge clk);
		repeat (4) @(posedge clk); q = bus;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk); cs_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
endmodule // apc_host

// File: tb/tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
// ==========================================================================
// bench
module tb;
	import apc_pkg::*;
	typedef struct packed {logic [7:0] b; logic [11:0] t; logic [7:0] lo, hi;} apc_row_t;
	logic clk = 0, rst = 1, pwr_n = 1, xclk = 0, comp = 0;
	logic [11:0] tgt = 0;
	logic cs_n, wr_n, rd_n, upper_sel, oe_n, done_n, track, intc, stby, full, span, sgn;
	logic [7:0] bus, dout, q;
	logic [11:0] trial;
	logic [2:0] ch;
	int n_errors = 0, total_checks = 0, cyc = 0;
	apc_row_t rows [4] = '{'{8'h4d, 12'ha5c, 8'h5c, 8'hfa}, '{8'h53, 12'ha5c, 8'h5c, 8'h0a},
		'{8'h0e, 12'h3c1, 8'hc1, 8'h03}, '{8'h17, 12'hfff, 8'hff, 8'h0f}};
	always #5 clk = ~clk;
	// comparator answers as an input held at tgt would; xclk is the external clock
	always @(posedge clk)
	begin
		comp <= tgt >= trial;
		cyc <= cyc + 1;
		if (cyc % 4 == 0) xclk <= ~xclk;
		if (cyc == 20000) begin n_errors++; stop_test(); end
	end
	apc_top #(.OSC_DIV(4)) i_apc_top (.CLK_IN(clk), .SYS_RST_IN(rst), .CS_N_IN(cs_n),
		.WR_N_IN(wr_n), .RD_N_IN(rd_n), .UPPER_BYTE_SELECT_IN(upper_sel), .POWER_OFF_N_IN(pwr_n),
		.EXT_CLK_IN(xclk), .DATA_IN(bus), .COMPARATOR_IN(comp), .DATA_OUT(dout),
		.DATA_OE_N_OUT(oe_n), .DONE_N_OUT(done_n), .TRACK_OUT(track), .TRIAL_CODE_OUT(trial),
		.INPUT_CHANNEL_SELECT_OUT(ch), .SPAN_SELECT_OUT(span), .SIGNED_SELECT_OUT(sgn),
		.INT_CLOCK_OUT(intc), .STANDBY_SLEEP_MODE_OUT(stby), .COMPLETE_SLEEP_MODE_OUT(full));
	apc_host i_apc_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .upper_sel(upper_sel),
		.dout(dout), .oe_n(oe_n), .bus(bus));
	task automatic chkw(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin n_errors++; $display("[FAIL] %0t %h %h", $time, got, exp); end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chkw({11'h0, got}, {11'h0, exp});
	endtask
	task automatic wait_done();
		int n;
		for (n = 0; n < 2000 && done_n !== 1'b0; n++) @(posedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk); rst <= 1'b0;
		repeat (4) @(posedge clk);
		chkb(done_n, 1'b1);
		chkb(oe_n, 1'b1);
		$display("test reset done");
		foreach (rows[i])
		begin
			tgt <= rows[i].t;
			i_apc_host.wr(rows[i].b, 1'b0);
			wait_done();
			chkb(done_n, 1'b0);
			chkw(trial, rows[i].t);
			chkw({7'h0, ch, span, sgn}, {7'h0, rows[i].b[2:0], rows[i].b[4:3]});
			chkb(intc, rows[i].b[7:6] == PCM_INT_CLOCK);
			i_apc_host.rd(1'b0, 1'b0, q);
			chkw({4'h0, q}, {4'h0, rows[i].lo});
			chkb(done_n, 1'b1);
			i_apc_host.rd(1'b1, 1'b0, q);
			chkw({4'h0, q}, {4'h0, rows[i].hi});
		end
		$display("test table done");
		i_apc_host.wr(8'h0e, 1'b1);
		chkb(track, 1'b0);
		chkw(trial, 12'hfff);
		i_apc_host.rd(1'b0, 1'b1, q);
		chkw({4'h0, q}, 12'h0f1);
		$display("test deselect done");
		tgt <= 12'h5a3;
		i_apc_host.wr(8'h20, 1'b0);
		repeat (100) @(posedge clk);
		chkb(track, 1'b1);
		i_apc_host.wr(8'h00, 1'b0);
		wait_done();
		chkw(trial, 12'h5a3);
		$display("test external acquire done");
		i_apc_host.wr(8'h80, 1'b0);
		chkb(stby, 1'b1);
		i_apc_host.wr(8'hc0, 1'b0);
		chkw({10'h0, full, track}, 12'h002);
		i_apc_host.wr(8'h00, 1'b0);
		pwr_n <= 1'b0;
		repeat (10) @(posedge clk);
		chkw({10'h0, full, track}, 12'h002);
		pwr_n <= 1'b1;
		repeat (10) @(posedge clk);
		chkb(full, 1'b0);
		$display("test power done");
		stop_test();
	end
endmodule // tb
